/* bench/oscdv_tb_top.sv */
/*
  Self-checking bench for the oscillator select and divider control block.
  Assumes a one-cycle Wishbone ack, straps sampled at reset and a clock
  standing for the selected oscillator output.
*/
`timescale 1ns/10ps
`default_nettype none
module oscdv_tb_top;
  typedef struct packed {
    logic [15:0] wr;
    logic [15:0] rb;
    logic [5:0]  n1;
    logic [3:0]  n2;
    logic [3:0]  sh;
    logic [7:0]  cnt;
  } oscdv_row_t;

  localparam logic [7:0] A_OSC = oscdv_pkg::ADR_OSC;
  localparam logic [7:0] A_DIV = oscdv_pkg::ADR_DIV;
  localparam logic [7:0] A_KEY = oscdv_pkg::ADR_KEY;
  // Write, readback, n1, n2, postscaler shift, processor pulses in 256 cycles
  localparam oscdv_row_t ROWS [9] = '{
    '{16'hffff, 16'hffdf, 6'h21, 4'h8, 4'h8, 8'h01},
    '{16'h0000, 16'h0000, 6'h02, 4'h2, 4'h0, 8'h80},
    '{16'h1d81, 16'h1d01, 6'h03, 4'h2, 4'h5, 8'h40},
    '{16'h2e40, 16'h2e40, 6'h02, 4'h4, 4'h6, 8'h20},
    '{16'h4b7f, 16'h4b5f, 6'h21, 4'h4, 4'h3, 8'h08},
    '{16'h5cc2, 16'h5cc2, 6'h04, 4'h8, 4'h4, 8'h04},
    '{16'h6901, 16'h6901, 6'h03, 4'h2, 4'h1, 8'h02},
    '{16'h3a00, 16'h3a00, 6'h02, 4'h2, 4'h2, 8'h10},
    '{16'h0800, 16'h0800, 6'h02, 4'h2, 4'h0, 8'h80}
  };

  logic                      clk_i;
  logic                      rst_i;
  logic                      cyc;
  logic                      stb;
  logic                      we;
  logic [7:0]                adr;
  logic [3:0]                sel;
  logic [31:0]               wdat;
  logic [31:0]               rdat;
  logic                      ack;
  oscdv_pkg::oscdv_cfg_t     cfg;
  logic                      pll_lk;
  logic                      src_rdy;
  logic                      tick;
  logic                      fail_det;
  logic                      irq;
  logic [2:0]                act;
  logic                      sec_en;
  oscdv_pkg::oscdv_clk_cfg_t ccfg;
  logic                      per_en;
  logic                      cpu_en;
  int                        failures;
  int                        checked;
  int                        cycles;
  int                        np;
  int                        nc;

  oscdv_top u_dut (
    .clk_i              (clk_i),
    .rst_i              (rst_i),
    .wb_cyc_i           (cyc),
    .wb_stb_i           (stb),
    .wb_we_i            (we),
    .wb_adr_i           (adr),
    .wb_sel_i           (sel),
    .wb_dat_i           (wdat),
    .wb_dat_o           (rdat),
    .wb_ack_o           (ack),
    .cfg_i              (cfg),
    .pll_locked_i       (pll_lk),
    .src_ready_i        (src_rdy),
    .new_clk_tick_i     (tick),
    .fail_detect_i      (fail_det),
    .irq_event_i        (irq),
    .active_source_o    (act),
    .secondary_osc_en_o (sec_en),
    .clk_cfg_o          (ccfg),
    .periph_clk_en_o    (per_en),
    .cpu_clk_en_o       (cpu_en)
  );

  always #5 clk_i = ~clk_i;

  task automatic complete_run();
    if (failures == 0 && checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : complete_run

  // Generous ceiling: the full sequence needs about 2700 cycles
  always @(posedge clk_i)
  begin
    cycles++;
    if (cycles == 8000)
    begin
      failures++;
      complete_run();
    end
  end

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      failures++;
      $display("wrong value %s: expected %h, seen %h", what, exp, seen);
    end
  endtask : check

  // Entered right after a rising edge; request held until ack is sampled
  task automatic wb_xfer(input logic w, input logic [7:0] a, input logic [15:0] d,
                         output logic [15:0] q);
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    adr  <= a;
    sel  <= 4'h3;
    wdat <= {16'h0000, d};
    // Only the bench timeout ends a wait for ack
    do
    begin
      @(posedge clk_i);
    end
    while (ack !== 1'b1);
    q = rdat[15:0];
    cyc <= 1'b0;
    stb <= 1'b0;
    we  <= 1'b0;
    @(posedge clk_i);
  endtask : wb_xfer

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    logic [15:0] q;
    wb_xfer(1'b1, a, d, q);
  endtask : wr

  task automatic rd_chk(input string what, input logic [7:0] a, input logic [15:0] exp);
    logic [15:0] q;
    wb_xfer(1'b0, a, 16'h0000, q);
    check(what, 32'(q), 32'(exp));
  endtask : rd_chk

  task automatic ctl_wr(input logic [15:0] d);
    wr(A_KEY, {8'h00, oscdv_pkg::KEY_FIRST});
    wr(A_KEY, {8'h00, oscdv_pkg::KEY_SECOND});
    wr(A_OSC, d);
  endtask : ctl_wr

  task automatic ticks(input int n);
    repeat (n)
    begin
      tick <= 1'b1;
      @(posedge clk_i);
      tick <= 1'b0;
      @(posedge clk_i);
    end
  endtask : ticks

  task automatic do_reset(input logic [5:0] straps);
    rst_i <= 1'b1;
    cfg   <= oscdv_pkg::oscdv_cfg_t'(straps);
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
  endtask : do_reset

  // Samples the settled values of the previous cycle at each edge
  task automatic count_window();
    np = 0;
    nc = 0;
    repeat (256)
    begin
      @(posedge clk_i);
      if (per_en === 1'b1) np++;
      if (cpu_en === 1'b1) nc++;
    end
  endtask : count_window

  initial
  begin
    clk_i = 1'b0;
    rst_i = 1'b1;
    {cyc, stb, we, adr, sel, wdat} = '0;
    cfg = '1;
    {pll_lk, src_rdy, tick, fail_det, irq} = '0;
    failures = 0;
    checked = 0;
    cycles = 0;
    for (int c = 0; c < 8; c++)
    begin
      do_reset({c[2:0], 2'h1, 1'b0});
      check("active_source", 32'(act), 32'(c));
      rd_chk("osc_reset", A_OSC, {1'b0, c[2:0], 1'b0, c[2:0], 8'h00});
      check("pll_en", 32'(ccfg.pll_en), 32'(c == 1 || c == 3));
      check("submode", 32'(ccfg.submode), (c == 2 || c == 3) ? 32'h1 : 32'h3);
      if (c == 6)
        check("div16", 32'(ccfg.frc_shift), 32'(oscdv_pkg::DIV16_SH));
    end
    // Erased part: every strap reads one
    do_reset(6'h3f);
    check("erased_source", 32'(act), 32'h7);
    rd_chk("osc_erased", A_OSC, 16'h7700);
    rd_chk("div_reset", A_DIV, 16'h3040);
    rd_chk("unmapped", 8'h0c, 16'h0000);
    foreach (ROWS[i])
    begin
      wr(A_DIV, ROWS[i].wr);
      rd_chk("divisor", A_DIV, ROWS[i].rb);
      check("n1", 32'(ccfg.n1), 32'(ROWS[i].n1));
      check("n2", 32'(ccfg.n2), 32'(ROWS[i].n2));
      check("frc_shift", 32'(ccfg.frc_shift), 32'(ROWS[i].sh));
      count_window();
      check("periph_pulses", 32'(np), 32'd128);
      check("cpu_pulses", 32'(nc), 32'(ROWS[i].cnt));
    end
    for (int r = 0; r < 2; r++)
    begin
      wr(A_DIV, r == 0 ? 16'h8b00 : 16'h0b00);
      irq <= 1'b1;
      @(posedge clk_i);
      irq <= 1'b0;
      @(posedge clk_i);
      rd_chk("recover", A_DIV, r == 0 ? 16'h8300 : 16'h0b00);
    end
    wr(A_OSC, 16'h0702);
    check("sec_no_unlock", 32'(sec_en), 32'h0);
    ctl_wr(16'h0702);
    check("sec_on", 32'(sec_en), 32'h1);
    fail_det <= 1'b1;
    @(posedge clk_i);
    fail_det <= 1'b0;
    @(posedge clk_i);
    rd_chk("fail_set", A_OSC, 16'h770a);
    // Switch to plain fast RC while the source is not yet ready
    ctl_wr(16'h0001);
    check("sec_off", 32'(sec_en), 32'h0);
    rd_chk("sw_pending", A_OSC, 16'h7001);
    ticks(10);
    check("not_ready", 32'(act), 32'h7);
    src_rdy <= 1'b1;
    repeat (2) @(posedge clk_i);
    ticks(9);
    check("nine_ticks", 32'(act), 32'h7);
    ticks(1);
    check("ten_ticks", 32'(act), 32'h0);
    rd_chk("sw_done", A_OSC, 16'h0000);
    ctl_wr(16'h0001);
    rd_chk("sw_same", A_OSC, 16'h0000);
    // Fast RC with PLL waits for lock before counting
    ctl_wr(16'h0101);
    ticks(12);
    check("no_lock", 32'(act), 32'h0);
    pll_lk <= 1'b1;
    repeat (2) @(posedge clk_i);
    ticks(10);
    check("pll_switch", 32'(act), 32'h1);
    rd_chk("lock_on", A_OSC, 16'h1120);
    fail_det <= 1'b1;
    @(posedge clk_i);
    fail_det <= 1'b0;
    @(posedge clk_i);
    rd_chk("fail_again", A_OSC, 16'h1128);
    ctl_wr(16'h0100);
    rd_chk("fail_clear", A_OSC, 16'h1120);
    pll_lk <= 1'b0;
    repeat (2) @(posedge clk_i);
    rd_chk("lock_off", A_OSC, 16'h1100);
    // Monitor strap is one, so the freeze bit takes hold
    ctl_wr(16'h0180);
    rd_chk("freeze_on", A_OSC, 16'h1180);
    ctl_wr(16'h0402);
    rd_chk("frozen_osc", A_OSC, 16'h1182);
    wr(A_DIV, 16'h0dc5);
    rd_chk("frozen_div", A_DIV, 16'h0b00);
    complete_run();
  end
endmodule : oscdv_tb_top
`default_nettype wire

/* rtl/oscdv_clock_divisor.sv */
/*
  Processor clock reduction: passes one tick out of 2**shift when enabled.
  Assumes tick_i is the instruction-rate clock enable.
*/
`timescale 1ns/10ps
`default_nettype none
module oscdv_clock_divisor (
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic       tick_i,
  input  wire logic       en_i,
  input  wire logic [2:0] shift_i,
  output logic            pulse_o
);
  oscdv_pkg::oscdv_div_state_t q;
  oscdv_pkg::oscdv_div_state_t d;
  logic [7:0]                  span;

  assign span = 8'h01 << shift_i;

  always_comb
  begin
    d       = q;
    d.pulse = 1'b0;
    if (tick_i)
    begin
      // A count left above a newly shortened span ends at once, not after a wrap
      if (!en_i || q.cnt >= 7'(span - 8'h01))
      begin
        d.pulse = 1'b1;
        d.cnt   = 7'h00;
      end
      else
        d.cnt = q.cnt + 7'h01;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      q <= '0;
    else
      q <= d;
  end

  assign pulse_o = q.pulse;

  property p_ratio_one;
    @(posedge clk_i) disable iff (rst_i)
    (!en_i && tick_i) |=> pulse_o;
  endproperty
  a_ratio_one: assert property (p_ratio_one)
    else $error("reduction off but tick not passed");

  property p_no_tick_no_pulse;
    @(posedge clk_i) disable iff (rst_i)
    !tick_i |=> !pulse_o;
  endproperty
  a_no_tick_no_pulse: assert property (p_no_tick_no_pulse)
    else $error("processor pulse without instruction tick");
endmodule : oscdv_clock_divisor
`default_nettype wire

/* rtl/oscdv_pkg.sv */
/*
  Constants, state encodings and carrier structs for the oscillator
  select and divider control block.
  Assumes a 32-bit classic Wishbone master and a clock that stands for
  the selected oscillator output.
*/
// Functional notes
// - Initial setting picks power-on clock source
// - Primary source: PLL by setting, submode by straps
// - Erased configuration starts fast RC divide-by-N
// - Read-only current source at bits 14-12
// - Writable requested source, loaded at power-on
// - Freeze bit plus monitor setting locks configuration
// - PLL status: locked and PLL in use
// - Clock fail flag: hardware sets, software clears
// - Bit 1 enables secondary oscillator
// - Bit 0 requests switch, cleared when done
// - Control register writes need unlock sequence
// - Interrupt clears reduction enable when recover set
// - Reduction divides by 1 to 128, reset 8
// - Reduction disabled forces ratio 1:1
// - Fast RC postscaler 1 to 64, then 256
// - PLL output divider 2, 4, 8; code 10 reserved
// - PLL input divider is field plus two
// - Unimplemented bits read as zero
// - Instruction and peripheral clock are oscillator/2
// - Valid switch clears status; same source aborts
// - Wait ten new-clock cycles before changeover
// - Completion copies requested to current, clears request
package oscdv_pkg;
  localparam logic [7:0] ADR_OSC      = 8'h00;
  localparam logic [7:0] ADR_DIV      = 8'h04;
  localparam logic [7:0] ADR_KEY      = 8'h08;
  localparam logic [7:0] KEY_FIRST    = 8'h5a;
  localparam logic [7:0] KEY_SECOND   = 8'ha5;
  localparam logic [2:0] SRC_FRC      = 3'h0;
  localparam logic [2:0] SRC_FAST_RC_WITH_PLL_MODE   = 3'h1;
  localparam logic [2:0] SRC_PRI      = 3'h2;
  localparam logic [2:0] SRC_PRIPLL   = 3'h3;
  localparam logic [2:0] SRC_DIV16    = 3'h6;
  localparam logic [2:0] SRC_DIVN     = 3'h7;
  localparam logic [1:0] SUB_NONE     = 2'h3;
  localparam logic [2:0] PROCESSOR_CLOCK_REDUCTION_RST     = 3'h3;
  localparam logic [2:0] FRC_RST      = 3'h0;
  localparam logic [2:0] FRC_MAX      = 3'h7;
  localparam logic [3:0] FRC_MAX_SH   = 4'h8;
  localparam logic [3:0] DIV16_SH     = 4'h4;
  localparam logic [1:0] POST_RST     = 2'h1;
  localparam logic [1:0] POST_RSVD    = 2'h2;
  localparam logic [4:0] PRE_RST      = 5'h00;
  localparam logic [5:0] PRE_OFFSET   = 6'h02;
  localparam logic [3:0] SETTLE_TICKS = 4'ha;

  typedef enum logic [1:0] {SW_IDLE, SW_WAIT, SW_COUNT} oscdv_sw_t;
  typedef enum logic [1:0] {KEY_IDLE, KEY_HALF, KEY_OPEN} oscdv_key_t;

  typedef struct packed {
    logic [2:0] init_src;
    logic [1:0] submode;
    logic       monitor;
  } oscdv_cfg_t;

  typedef struct packed {
    logic       pll_en;
    logic [1:0] submode;
    logic [3:0] frc_shift;
    logic [5:0] n1;
    logic [3:0] n2;
  } oscdv_clk_cfg_t;

  typedef struct packed {
    oscdv_sw_t      sw_st;
    logic [3:0]     ticks;
    logic [2:0]     cur_src;
    logic [2:0]     req_src;
    logic           freeze;
    logic           lock;
    logic           fail;
    logic           sec_en;
    logic           sw_req;
    logic           recover_on_interrupt_bit;
    logic [2:0]     processor_clock_reduction;
    logic           reduction_enable_bit;
    logic [2:0]     fast_rc_postscaler;
    logic [1:0]     post;
    logic [4:0]     pre;
    logic           fcy;
    logic           ack;
    logic [31:0]    rdat;
    oscdv_clk_cfg_t clk;
  } oscdv_state_t;

  typedef struct packed {
    logic [6:0] cnt;
    logic       pulse;
  } oscdv_div_state_t;
endpackage : oscdv_pkg

/* rtl/oscdv_top.sv */
/*
  Oscillator select and divider control: control and divisor registers
  on a classic Wishbone slave, switch sequencing and clock enables.
  Assumes the oscillator, PLL and fail-safe monitor sit outside and
  report through level inputs; new_clk_tick_i pulses once per cycle of
  the source being switched to.
*/
`timescale 1ns/10ps
`default_nettype none
module oscdv_top (
  input  wire logic                      clk_i,
  input  wire logic                      rst_i,
  input  wire logic                      wb_cyc_i,
  input  wire logic                      wb_stb_i,
  input  wire logic                      wb_we_i,
  input  wire logic [7:0]                wb_adr_i,
  input  wire logic [3:0]                wb_sel_i,
  input  wire logic [31:0]               wb_dat_i,
  output logic      [31:0]               wb_dat_o,
  output logic                           wb_ack_o,
  input  wire oscdv_pkg::oscdv_cfg_t     cfg_i,
  input  wire logic                      pll_locked_i,
  input  wire logic                      src_ready_i,
  input  wire logic                      new_clk_tick_i,
  input  wire logic                      fail_detect_i,
  input  wire logic                      irq_event_i,
  output logic      [2:0]                active_source_o,
  output logic                           secondary_osc_en_o,
  output oscdv_pkg::oscdv_clk_cfg_t      clk_cfg_o,
  output logic                           periph_clk_en_o,
  output logic                           cpu_clk_en_o
);
  oscdv_pkg::oscdv_state_t st_q;
  oscdv_pkg::oscdv_state_t st_d;
  oscdv_pkg::oscdv_state_t st_rst;
  logic                    req_take;
  logic                    wr_osc;
  logic                    wr_div;
  logic                    wr_key;
  logic                    key_open;
  logic                    frozen;
  logic                    pll_on;
  logic [15:0]             osc_rd;
  logic [15:0]             div_rd;

  function automatic logic uses_pll(input logic [2:0] src);
    return src == oscdv_pkg::SRC_FAST_RC_WITH_PLL_MODE || src == oscdv_pkg::SRC_PRIPLL;
  endfunction : uses_pll

  function automatic logic [3:0] post_ratio(input logic [1:0] code);
    logic [3:0] r;
    r = 4'h2;
    unique case (code)
      2'h0:    r = 4'h2;
      2'h1:    r = 4'h4;
      default: r = 4'h8;
    endcase
    return r;
  endfunction : post_ratio

  // One-cycle ack; the second cycle of a held request is not a new one
  assign req_take = wb_cyc_i && wb_stb_i && !st_q.ack;
  assign wr_osc   = req_take && wb_we_i && wb_adr_i == oscdv_pkg::ADR_OSC && key_open;
  assign wr_div   = req_take && wb_we_i && wb_adr_i == oscdv_pkg::ADR_DIV;
  assign wr_key   = req_take && wb_we_i && wb_adr_i == oscdv_pkg::ADR_KEY && wb_sel_i[0];
  assign frozen   = st_q.freeze && cfg_i.monitor;
  assign pll_on   = uses_pll(st_q.cur_src)
                    || (st_q.sw_st != oscdv_pkg::SW_IDLE && uses_pll(st_q.req_src));

  // Unimplemented positions are tied to zero in the read images
  assign osc_rd = {1'b0, st_q.cur_src, 1'b0, st_q.req_src, st_q.freeze, 1'b0,
                   st_q.lock, 1'b0, st_q.fail, 1'b0, st_q.sec_en, st_q.sw_req};
  assign div_rd = {st_q.recover_on_interrupt_bit, st_q.processor_clock_reduction, st_q.reduction_enable_bit, st_q.fast_rc_postscaler,
                   st_q.post, 1'b0, st_q.pre};

  oscdv_unlock u_unlock (
    .clk_i     (clk_i),
    .rst_i     (rst_i),
    .key_we_i  (wr_key),
    .key_i     (wb_dat_i[7:0]),
    .consume_i (req_take && wb_we_i && wb_adr_i == oscdv_pkg::ADR_OSC),
    .open_o    (key_open)
  );

  // Synchronous reset lets the configuration straps seed the sources
  always_comb
  begin
    st_rst         = '0;
    st_rst.sw_st   = oscdv_pkg::SW_IDLE;
    st_rst.cur_src = cfg_i.init_src;
    st_rst.req_src = cfg_i.init_src;
    st_rst.processor_clock_reduction    = oscdv_pkg::PROCESSOR_CLOCK_REDUCTION_RST;
    st_rst.fast_rc_postscaler  = oscdv_pkg::FRC_RST;
    st_rst.post    = oscdv_pkg::POST_RST;
    st_rst.pre     = oscdv_pkg::PRE_RST;
  end

  always_comb
  begin
    st_d      = st_q;
    st_d.ack  = req_take;
    st_d.rdat = '0;
    if (req_take && !wb_we_i)
    begin
      if (wb_adr_i == oscdv_pkg::ADR_OSC)
        st_d.rdat[15:0] = osc_rd;
      else if (wb_adr_i == oscdv_pkg::ADR_DIV)
        st_d.rdat[15:0] = div_rd;
    end

    if (wr_osc && wb_sel_i[1] && !frozen)
      st_d.req_src = wb_dat_i[10:8];
    if (wr_osc && wb_sel_i[0])
    begin
      st_d.sec_en = wb_dat_i[1];
      if (!frozen)
      begin
        st_d.freeze = wb_dat_i[7];
        st_d.sw_req = st_q.sw_req | wb_dat_i[0];
      end
      if (!wb_dat_i[3])
        st_d.fail = 1'b0;
    end

    if (wr_div && wb_sel_i[1])
    begin
      st_d.recover_on_interrupt_bit   = wb_dat_i[15];
      st_d.processor_clock_reduction  = wb_dat_i[14:12];
      st_d.reduction_enable_bit = wb_dat_i[11];
      if (!frozen)
        st_d.fast_rc_postscaler = wb_dat_i[10:8];
    end
    if (wr_div && wb_sel_i[0] && !frozen)
    begin
      st_d.pre = wb_dat_i[4:0];
      // Reserved divider code is refused so the PLL never sees it
      if (wb_dat_i[7:6] != oscdv_pkg::POST_RSVD)
        st_d.post = wb_dat_i[7:6];
    end

    if (irq_event_i && st_q.recover_on_interrupt_bit)
      st_d.reduction_enable_bit = 1'b0;

    st_d.lock = pll_locked_i && pll_on;

    unique case (st_q.sw_st)
      oscdv_pkg::SW_IDLE:
        if (st_q.sw_req)
        begin
          if (st_q.req_src == st_q.cur_src)
            st_d.sw_req = 1'b0;
          else
          begin
            st_d.lock  = 1'b0;
            st_d.fail  = 1'b0;
            st_d.sw_st = oscdv_pkg::SW_WAIT;
          end
        end
      oscdv_pkg::SW_WAIT:
        if (src_ready_i && (!uses_pll(st_q.req_src) || pll_locked_i))
        begin
          st_d.ticks = 4'h0;
          st_d.sw_st = oscdv_pkg::SW_COUNT;
        end
      oscdv_pkg::SW_COUNT:
        if (new_clk_tick_i)
        begin
          if (st_q.ticks == oscdv_pkg::SETTLE_TICKS - 4'h1)
          begin
            st_d.cur_src = st_q.req_src;
            st_d.sw_req  = 1'b0;
            st_d.sw_st   = oscdv_pkg::SW_IDLE;
          end
          else
            st_d.ticks = st_q.ticks + 4'h1;
        end
    endcase

    // A failure seen in the cycle software clears the flag is kept
    if (fail_detect_i)
      st_d.fail = 1'b1;

    st_d.fcy = !st_q.fcy;

    st_d.clk.pll_en = uses_pll(st_d.cur_src);
    st_d.clk.n1     = {1'b0, st_d.pre} + oscdv_pkg::PRE_OFFSET;
    st_d.clk.n2     = post_ratio(st_d.post);
    if (st_d.cur_src == oscdv_pkg::SRC_PRI || st_d.cur_src == oscdv_pkg::SRC_PRIPLL)
      st_d.clk.submode = cfg_i.submode;
    else
      st_d.clk.submode = oscdv_pkg::SUB_NONE;
    if (st_d.cur_src == oscdv_pkg::SRC_DIVN)
      st_d.clk.frc_shift = (st_d.fast_rc_postscaler == oscdv_pkg::FRC_MAX) ? oscdv_pkg::FRC_MAX_SH
                           : {1'b0, st_d.fast_rc_postscaler};
    else if (st_d.cur_src == oscdv_pkg::SRC_DIV16)
      st_d.clk.frc_shift = oscdv_pkg::DIV16_SH;
    else
      st_d.clk.frc_shift = 4'h0;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      st_q <= st_rst;
    else
      st_q <= st_d;
  end

  // Reduction gates only the processor; peripherals keep the full rate
  oscdv_clock_divisor u_reduce (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .tick_i  (st_d.fcy),
    .en_i    (st_q.reduction_enable_bit),
    .shift_i (st_q.processor_clock_reduction),
    .pulse_o (cpu_clk_en_o)
  );

  assign periph_clk_en_o    = st_q.fcy;
  assign wb_ack_o           = st_q.ack;
  assign wb_dat_o           = st_q.rdat;
  assign active_source_o    = st_q.cur_src;
  assign secondary_osc_en_o = st_q.sec_en;
  assign clk_cfg_o          = st_q.clk;

  property p_same_source_abort;
    @(posedge clk_i) disable iff (rst_i)
    (st_q.sw_st == oscdv_pkg::SW_IDLE && st_q.sw_req && st_q.req_src == st_q.cur_src)
      |=> !st_q.sw_req && st_q.sw_st == oscdv_pkg::SW_IDLE;
  endproperty
  a_same_source_abort: assert property (p_same_source_abort)
    else $error("redundant switch request not dropped");

  property p_start_clears;
    @(posedge clk_i) disable iff (rst_i)
    (st_q.sw_st == oscdv_pkg::SW_IDLE && st_q.sw_req && st_q.req_src != st_q.cur_src
     && !fail_detect_i) |=> !st_q.lock && !st_q.fail && st_q.sw_st == oscdv_pkg::SW_WAIT;
  endproperty
  a_start_clears: assert property (p_start_clears)
    else $error("switch start left lock or fail set");

  property p_change_after_ten;
    @(posedge clk_i) disable iff (rst_i)
    $changed(st_q.cur_src) |-> $past(st_q.ticks) == 4'h9 && $past(new_clk_tick_i)
                               && !st_q.sw_req && st_q.cur_src == $past(st_q.req_src);
  endproperty
  a_change_after_ten: assert property (p_change_after_ten)
    else $error("source changed without ten settle ticks");

  property p_fail_sets;
    @(posedge clk_i) disable iff (rst_i)
    fail_detect_i |=> st_q.fail;
  endproperty
  a_fail_sets: assert property (p_fail_sets)
    else $error("clock fail flag not set");

  property p_recover;
    @(posedge clk_i) disable iff (rst_i)
    (irq_event_i && st_q.recover_on_interrupt_bit) |=> !st_q.reduction_enable_bit ##1 cpu_clk_en_o == periph_clk_en_o;
  endproperty
  a_recover: assert property (p_recover)
    else $error("interrupt did not restore full processor rate");

  property p_frozen_holds;
    @(posedge clk_i) disable iff (rst_i)
    (frozen && wr_div) |=> $stable(st_q.pre) && $stable(st_q.post) && $stable(st_q.fast_rc_postscaler);
  endproperty
  a_frozen_holds: assert property (p_frozen_holds)
    else $error("frozen PLL configuration changed");

  property p_locked_write;
    @(posedge clk_i) disable iff (rst_i)
    (req_take && wb_we_i && wb_adr_i == oscdv_pkg::ADR_OSC && !key_open)
      |=> $stable(st_q.sec_en) && $stable(st_q.req_src);
  endproperty
  a_locked_write: assert property (p_locked_write)
    else $error("control register changed without unlock");

  property p_lock_needs_pll;
    @(posedge clk_i) disable iff (rst_i)
    (!pll_on || !pll_locked_i) |=> !st_q.lock;
  endproperty
  a_lock_needs_pll: assert property (p_lock_needs_pll)
    else $error("lock status high without locked PLL in use");

  property p_zero_bits;
    @(posedge clk_i) disable iff (rst_i)
    (req_take && !wb_we_i) |=> wb_ack_o && wb_dat_o[31:16] == 16'h0000
      && (wb_dat_o[15:0] & (($past(wb_adr_i) == oscdv_pkg::ADR_DIV) ? 16'h0020 : 16'h8854))
         == 16'h0000 ##1 !wb_ack_o;
  endproperty
  a_zero_bits: assert property (p_zero_bits)
    else $error("unimplemented bits read nonzero");

  property p_post_reserved;
    @(posedge clk_i) disable iff (rst_i)
    st_q.post != oscdv_pkg::POST_RSVD;
  endproperty
  a_post_reserved: assert property (p_post_reserved)
    else $error("reserved output divider code stored");

  property p_submode_primary;
    @(posedge clk_i) disable iff (rst_i)
    (!$past(rst_i) && (active_source_o == oscdv_pkg::SRC_PRI
     || active_source_o == oscdv_pkg::SRC_PRIPLL)) |-> clk_cfg_o.submode == cfg_i.submode;
  endproperty
  a_submode_primary: assert property (p_submode_primary)
    else $error("primary submode not passed to the oscillator");

  property p_periph_toggle;
    @(posedge clk_i) disable iff (rst_i)
    !$past(rst_i) |-> periph_clk_en_o != $past(periph_clk_en_o);
  endproperty
  a_periph_toggle: assert property (p_periph_toggle)
    else $error("peripheral enable not at half the clock rate");

  property p_current_read_only;
    @(posedge clk_i) disable iff (rst_i)
    (wr_osc && st_q.sw_st == oscdv_pkg::SW_IDLE) |=> $stable(active_source_o);
  endproperty
  a_current_read_only: assert property (p_current_read_only)
    else $error("current source changed by a register write");

  property p_secondary_follows;
    @(posedge clk_i) disable iff (rst_i)
    (wr_osc && wb_sel_i[0]) |=> secondary_osc_en_o == $past(wb_dat_i[1]);
  endproperty
  a_secondary_follows: assert property (p_secondary_follows)
    else $error("secondary enable does not follow the written bit");

  property p_fail_no_soft_set;
    @(posedge clk_i) disable iff (rst_i)
    (!fail_detect_i && !st_q.fail) |=> !st_q.fail;
  endproperty
  a_fail_no_soft_set: assert property (p_fail_no_soft_set)
    else $error("clock fail flag set without a detected failure");

  property p_input_divider;
    @(posedge clk_i) disable iff (rst_i)
    !$past(rst_i) |-> clk_cfg_o.n1 == {1'b0, st_q.pre} + oscdv_pkg::PRE_OFFSET;
  endproperty
  a_input_divider: assert property (p_input_divider)
    else $error("input divider is not the field plus two");
endmodule : oscdv_top
`default_nettype wire

/* rtl/oscdv_unlock.sv */
/*
  Unlock sequencer: two key writes in a row open one protected write.
  Assumes key writes arrive as one-cycle strobes from the bus slave.
*/
`timescale 1ns/10ps
`default_nettype none
module oscdv_unlock (
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic       key_we_i,
  input  wire logic [7:0] key_i,
  input  wire logic       consume_i,
  output logic            open_o
);
  oscdv_pkg::oscdv_key_t st_q;
  oscdv_pkg::oscdv_key_t st_d;

  always_comb
  begin
    st_d = st_q;
    if (consume_i)
      st_d = oscdv_pkg::KEY_IDLE;
    else if (key_we_i)
    begin
      // A wrong key anywhere restarts the sequence
      if (key_i == oscdv_pkg::KEY_FIRST)
        st_d = oscdv_pkg::KEY_HALF;
      else if (key_i == oscdv_pkg::KEY_SECOND && st_q == oscdv_pkg::KEY_HALF)
        st_d = oscdv_pkg::KEY_OPEN;
      else
        st_d = oscdv_pkg::KEY_IDLE;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      st_q <= oscdv_pkg::KEY_IDLE;
    else
      st_q <= st_d;
  end

  assign open_o = (st_q == oscdv_pkg::KEY_OPEN);

  property p_key_open;
    @(posedge clk_i) disable iff (rst_i)
    (st_q == oscdv_pkg::KEY_HALF && key_we_i && !consume_i
     && key_i == oscdv_pkg::KEY_SECOND) |=> open_o ##1 (open_o || $past(consume_i));
  endproperty
  a_key_open: assert property (p_key_open)
    else $error("unlock did not open after key pair");
endmodule : oscdv_unlock
`default_nettype wire
